// ==== design/psef_top.sv ====
// Event flags, interrupt masks, autorun chain of the power stages and output matrix of the third stage
//
// Contract
// - Matrix A bits 1 and 0 set third stage output A level in ramps 1, 0.
// - Mask bit 5 lets a set sync error flag raise the stage interrupt request.
// - Mask bit 4 lets an event B raise the stage interrupt request.
// - Mask bit 3 lets an event A raise the stage interrupt request.
// - Mask bit 0 lets end of whole cycle raise the stage interrupt request.
// - Flag bit 7 sets on every toggle of stage output B.
// - Flag bit 6 sets on every toggle of stage output A.
// - Flag bit 5 sets when an autorun stage mismatches its preceding stage timing.
// - Flag bit 4 sets on every block B event, readable even when masked.
// - Flag bit 3 sets on every block A event, readable even when masked.
// - Every event flag stays set until software writes one to it.
// - Flag bits 2:1 hold the ramp of the last A or B event.
// - Flag bit 0 sets each time the stage completes its whole cycle.
// - An autorun stage runs with its preceding stage's run signal.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module psef_top #(
	parameter int STAGES = psef_pkg::STAGE_COUNT
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [psef_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [psef_pkg::DATA_W-1:0] avs_writedata,
	output logic [psef_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire psef_pkg::psef_stage_in_type [STAGES-1:0] stage_in,
	output logic [STAGES-1:0] stage_run,
	output logic [STAGES-1:0] stage_irq_req,
	output psef_pkg::psef_matrix_out_type matrix_out,
	output logic irq
);

	//////////////////////////////////////////////////////////////////////
	// Address decode, used for every register
	function automatic logic hit(input logic [psef_pkg::ADDR_W-1:0] addr,
			input logic [psef_pkg::ADDR_W-1:0] ofs);
		hit = (addr & psef_pkg::OFS_WORD_MASK) == ofs;
	endfunction

	psef_pkg::psef_bus_state_type bus_state;
	logic wr_take;
	logic rd_take;
	logic [7:0] wr_byte;
	logic [psef_pkg::DATA_W-1:0] next_readdata;

	logic [7:0] mask [STAGES];
	logic [7:0] flag_evt [STAGES];
	logic [1:0] last_event_ramp [STAGES];
	logic [7:0] flag_read [STAGES];
	logic [7:0] flag_set [STAGES];
	logic [STAGES-1:0] prev_out_a;
	logic [STAGES-1:0] prev_out_b;
	logic primed;
	logic [7:0] control;
	logic [7:0] matrix;
	logic [STAGES-1:0] irq_status;
	logic [STAGES-1:0] irq_mask;
	logic [STAGES-1:0] stage_event;
	logic [STAGES-1:0] run_bit;
	logic [STAGES-1:0] chained_autorun;
	logic [STAGES-1:0] next_stage_run;

	// Writes land only at the edge where waitrequest is seen low
	assign wr_take = avs_write && !avs_waitrequest;
	assign rd_take = avs_read && !avs_waitrequest;
	assign wr_byte = avs_byteenable[0] ? avs_writedata[7:0] : psef_pkg::RESET_BYTE;
	assign run_bit = control[psef_pkg::CTRL_RUN_LSB +: STAGES];
	assign chained_autorun = control[psef_pkg::CTRL_AUTORUN_LSB +: STAGES];

	//////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then the answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_state <= psef_pkg::PSEF_BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			case (bus_state)
				psef_pkg::PSEF_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state <= psef_pkg::PSEF_BUS_ANSWER;
						avs_waitrequest <= 1'b0;
					end
				end
				psef_pkg::PSEF_BUS_ANSWER: begin
					bus_state <= psef_pkg::PSEF_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
				default: begin
					bus_state <= psef_pkg::PSEF_BUS_IDLE;
					avs_waitrequest <= 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		next_readdata = psef_pkg::RESET_WORD;
		for (int i = 0; i < STAGES; i++) begin
			if (hit(avs_address, psef_pkg::OFS_MASK0 + 8'(i) * psef_pkg::OFS_STRIDE)) begin
				next_readdata[7:0] = mask[i];
			end
			if (hit(avs_address, psef_pkg::OFS_FLAGS0 + 8'(i) * psef_pkg::OFS_STRIDE)) begin
				next_readdata[7:0] = flag_read[i];
			end
		end
		if (hit(avs_address, psef_pkg::OFS_CONTROL)) begin
			next_readdata[7:0] = control;
		end
		if (hit(avs_address, psef_pkg::OFS_MATRIX)) begin
			next_readdata[7:0] = matrix;
		end
		if (hit(avs_address, psef_pkg::OFS_IRQ_STATUS)) begin
			next_readdata[STAGES-1:0] = irq_status;
		end
		if (hit(avs_address, psef_pkg::OFS_IRQ_MASK)) begin
			next_readdata[STAGES-1:0] = irq_mask;
		end
	end

	// Read data is loaded as waitrequest drops and holds through the answer edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= psef_pkg::RESET_WORD;
		end else if (bus_state == psef_pkg::PSEF_BUS_IDLE && avs_read) begin
			avs_readdata <= next_readdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Software control: run, autorun, matrix enable and matrix values
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control <= psef_pkg::RESET_BYTE;
		end else if (wr_take && hit(avs_address, psef_pkg::OFS_CONTROL)) begin
			control <= wr_byte & psef_pkg::CTRL_WRITABLE;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			matrix <= psef_pkg::RESET_BYTE;
		end else if (wr_take && hit(avs_address, psef_pkg::OFS_MATRIX)) begin
			matrix <= wr_byte;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= psef_pkg::RESET_STAGES;
		end else if (wr_take && hit(avs_address, psef_pkg::OFS_IRQ_MASK)) begin
			irq_mask <= wr_byte[STAGES-1:0];
		end
	end

	// Blocks the toggle flags until the previous output levels are known
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			primed <= 1'b0;
		end else begin
			primed <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Per stage flags, masks and run chain
	for (genvar n = 0; n < STAGES; n++) begin : g_stage
		localparam int PREV = (n + STAGES - 1) % STAGES;
		localparam int PREV2 = (n + STAGES - 2) % STAGES;
		logic sync_err;
		logic [7:0] flag_clr;

		// Autorun follows the preceding stage, two hops at most so a full ring cannot loop
		assign next_stage_run[n] = run_bit[n] || (chained_autorun[n] && (run_bit[PREV] ||
			(chained_autorun[PREV] && run_bit[PREV2])));

		assign sync_err = chained_autorun[n] && stage_run[n] &&
			((stage_in[n].update != stage_in[PREV].update) ||
			(stage_in[n].end_cycle != stage_in[PREV].end_cycle));

		always_comb begin
			flag_set[n] = psef_pkg::RESET_BYTE;
			flag_set[n][psef_pkg::BIT_OUT_B_ACT] = primed &&
				(stage_in[n].stage_output_b != prev_out_b[n]);
			flag_set[n][psef_pkg::BIT_OUT_A_ACT] = primed &&
				(stage_in[n].stage_output_a != prev_out_a[n]);
			flag_set[n][psef_pkg::BIT_SYNC_ERR] = sync_err;
			flag_set[n][psef_pkg::BIT_EVENT_B] = stage_in[n].event_b;
			flag_set[n][psef_pkg::BIT_EVENT_A] = stage_in[n].event_a;
			flag_set[n][psef_pkg::BIT_END_CYCLE] = stage_in[n].end_cycle;
		end

		assign flag_clr = (wr_take && hit(avs_address,
			psef_pkg::OFS_FLAGS0 + 8'(n) * psef_pkg::OFS_STRIDE)) ?
			(wr_byte & psef_pkg::FLAG_CLEARABLE) : psef_pkg::RESET_BYTE;

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				prev_out_a[n] <= 1'b0;
				prev_out_b[n] <= 1'b0;
			end else begin
				prev_out_a[n] <= stage_in[n].stage_output_a;
				prev_out_b[n] <= stage_in[n].stage_output_b;
			end
		end

		// A new event in the clearing cycle survives the clear
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				flag_evt[n] <= psef_pkg::RESET_BYTE;
			end else begin
				flag_evt[n] <= (flag_evt[n] & ~flag_clr) | flag_set[n];
			end
		end

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				last_event_ramp[n] <= psef_pkg::RESET_BYTE[1:0];
			end else if (stage_in[n].event_a || stage_in[n].event_b) begin
				last_event_ramp[n] <= stage_in[n].ramp;
			end
		end

		always_comb begin
			flag_read[n] = flag_evt[n];
			flag_read[n][psef_pkg::BIT_RAMP_HI:psef_pkg::BIT_RAMP_LO] = last_event_ramp[n];
		end

		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				mask[n] <= psef_pkg::RESET_BYTE;
			end else if (wr_take &&
					hit(avs_address, psef_pkg::OFS_MASK0 + 8'(n) * psef_pkg::OFS_STRIDE)) begin
				mask[n] <= wr_byte & psef_pkg::MASK_WRITABLE;
			end
		end

		// Same positions in both registers, so the mask gates the flag bit for bit
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				stage_irq_req[n] <= 1'b0;
			end else begin
				stage_irq_req[n] <= |(flag_evt[n] & mask[n]);
			end
		end

		assign stage_event[n] = |(flag_set[n] & mask[n]);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage_run <= psef_pkg::RESET_STAGES;
		end else begin
			stage_run <= next_stage_run;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Summary interrupt: sticky per stage, cleared by reading, set wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= psef_pkg::RESET_STAGES;
		end else if (rd_take && hit(avs_address, psef_pkg::OFS_IRQ_STATUS)) begin
			irq_status <= stage_event;
		end else begin
			irq_status <= irq_status | stage_event;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Output matrix of the third stage; pass-through when disabled
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			matrix_out <= '0;
		end else if (control[psef_pkg::CTRL_MATRIX_EN]) begin
			matrix_out.stage2_output_a0 <=
				matrix[psef_pkg::MATRIX_A_LSB + stage_in[psef_pkg::MATRIX_STAGE].ramp];
			matrix_out.stage2_output_a2 <=
				matrix[psef_pkg::MATRIX_A_LSB + stage_in[psef_pkg::MATRIX_STAGE].ramp];
			matrix_out.stage2_output_b1 <=
				matrix[psef_pkg::MATRIX_B_LSB + stage_in[psef_pkg::MATRIX_STAGE].ramp];
			matrix_out.stage2_output_b3 <=
				matrix[psef_pkg::MATRIX_B_LSB + stage_in[psef_pkg::MATRIX_STAGE].ramp];
		end else begin
			matrix_out.stage2_output_a0 <= stage_in[psef_pkg::MATRIX_STAGE].stage_output_a;
			matrix_out.stage2_output_a2 <= stage_in[psef_pkg::MATRIX_STAGE].stage_output_a;
			matrix_out.stage2_output_b1 <= stage_in[psef_pkg::MATRIX_STAGE].stage_output_b;
			matrix_out.stage2_output_b3 <= stage_in[psef_pkg::MATRIX_STAGE].stage_output_b;
		end
	end

endmodule

// ==== design/psef_pkg.sv ====
// Package for the power stage event flag block: offsets, fields, types
package psef_pkg;
	localparam int STAGE_COUNT = 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int MATRIX_STAGE = 2;
	//////////////////////////////////////////////////////////////////////
	// Byte offsets on the register bus
	localparam logic [ADDR_W-1:0] OFS_MASK0 = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_MASK1 = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_MASK2 = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FLAGS0 = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_FLAGS1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_FLAGS2 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_MATRIX = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_STRIDE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WORD_MASK = 8'hFC;
	//////////////////////////////////////////////////////////////////////
	// Field positions, shared by mask and flag registers
	localparam int BIT_END_CYCLE = 0;
	localparam int BIT_RAMP_LO = 1;
	localparam int BIT_RAMP_HI = 2;
	localparam int BIT_EVENT_A = 3;
	localparam int BIT_EVENT_B = 4;
	localparam int BIT_SYNC_ERR = 5;
	localparam int BIT_OUT_A_ACT = 6;
	localparam int BIT_OUT_B_ACT = 7;
	localparam logic [7:0] MASK_WRITABLE = 8'h39;
	localparam logic [7:0] FLAG_CLEARABLE = 8'hF9;
	// Control register fields
	localparam int CTRL_RUN_LSB = 0;
	localparam int CTRL_AUTORUN_LSB = 3;
	localparam int CTRL_MATRIX_EN = 6;
	localparam logic [7:0] CTRL_WRITABLE = 8'h7F;
	// Matrix register fields
	localparam int MATRIX_A_LSB = 0;
	localparam int MATRIX_B_LSB = 4;
	//////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
	localparam logic [STAGE_COUNT-1:0] RESET_STAGES = 3'h0;
	//////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		PSEF_BUS_IDLE = 2'b01,
		PSEF_BUS_ANSWER = 2'b10
	} psef_bus_state_type;
	// Per stage signals from the waveform engine, same clock
	typedef struct packed {
		logic stage_output_a;
		logic stage_output_b;
		logic update;
		logic end_cycle;
		logic event_a;
		logic event_b;
		logic [1:0] ramp;
	} psef_stage_in_type;
	// Third stage pins after the output matrix
	typedef struct packed {
		logic stage2_output_a0;
		logic stage2_output_a2;
		logic stage2_output_b1;
		logic stage2_output_b3;
	} psef_matrix_out_type;
endpackage

// ==== testbench/psef_monitor.sv ====
// Checker for the bus handshake, interrupt requests and run signals
`timescale 1ns/1ps
module psef_monitor #(
	parameter int STAGES = 3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [psef_pkg::DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire psef_pkg::psef_stage_in_type [STAGES-1:0] stage_in,
	input wire logic [STAGES-1:0] stage_run,
	input wire logic [STAGES-1:0] stage_irq_req,
	input wire logic irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic done;
	logic any_pulse;
	assign done = avs_write && !avs_waitrequest;
	assign any_pulse = |(stage_in & {STAGES{8'h3C}});
	//////////////////////////////////////////////////////////////////////
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("Request not answered in one cycle");
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("Waitrequest low for more than one cycle");
	a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("Waitrequest dropped without a request");
	a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[psef_pkg::DATA_W-1:8] == '0)
		else $error("Read data upper bits not zero");
	a_req_fall: assert property (
		(|($past(stage_irq_req) & ~stage_irq_req)) |-> $past(done, 2))
		else $error("Stage request dropped without a write");
	a_irq_fall: assert property (
		$fell(irq) |-> $past(avs_read || avs_write) || $past(avs_read || avs_write, 2))
		else $error("Interrupt dropped without an access");
	a_run_by_write: assert property (
		$changed(stage_run) |-> $past(done) || $past(done, 2))
		else $error("Run signal changed without a control write");
	for (genvar g = 0; g < STAGES; g++) begin : gen_st
		a_req_rise: assert property (
			$rose(stage_irq_req[g]) |-> $past(done, 2) || $past(any_pulse, 2)
			|| $past(stage_in[g].stage_output_a, 2) != $past(stage_in[g].stage_output_a, 3)
			|| $past(stage_in[g].stage_output_b, 2) != $past(stage_in[g].stage_output_b, 3))
			else $error("Stage request rose without a cause");
	end
	c_read: cover property (avs_read && !avs_waitrequest);
	c_irq: cover property ($rose(irq));
	c_req: cover property ($rose(stage_irq_req[1]));
endmodule

// ==== testbench/psef_engine_model.sv ====
// Behavioural waveform engine that feeds the stage inputs
`timescale 1ns/1ps
module psef_engine_model #(
	parameter int STAGES = 3
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire psef_pkg::psef_stage_in_type [STAGES-1:0] cmd,
	output psef_pkg::psef_stage_in_type [STAGES-1:0] stage_in
);
	// Launched from a flop, as a real engine does, so pulses last one cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage_in <= '0;
		end else begin
			stage_in <= cmd;
		end
	end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the power stage event flag block
`timescale 1ns/1ps
module tb_top;
	localparam int STAGES = psef_pkg::STAGE_COUNT;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	psef_pkg::psef_stage_in_type [STAGES-1:0] cmd = '0;
	psef_pkg::psef_stage_in_type [STAGES-1:0] stage_in;
	logic [STAGES-1:0] stage_run;
	logic [STAGES-1:0] stage_irq_req;
	psef_pkg::psef_matrix_out_type matrix_out;
	logic irq;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [7:0] q;
	logic [7:0] ex;
	logic [1:0] r;
	logic [1:0] lr [3];
	logic [7:0] mk [3] = '{8'h01, 8'h08, 8'h10};
	int kk [3] = '{4, 3, 2};
	always #5 clk_sys = ~clk_sys;
	psef_top #(.STAGES(STAGES)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(4'h1),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stage_in(stage_in), .stage_run(stage_run),
		.stage_irq_req(stage_irq_req), .matrix_out(matrix_out), .irq(irq));
	psef_engine_model #(.STAGES(STAGES)) u_eng (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(cmd),
		.stage_in(stage_in));
	//////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Expected flag byte: event bits plus the ramp of the last A or B event
	function automatic logic [7:0] exp_flags(input logic [1:0] rr, input logic [7:0] ev);
		exp_flags = ev | {5'h00, rr, 1'b0};
	endfunction
	// Request held until waitrequest is seen low; read data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// One-cycle pulse on field k of stage n, then time for flag, request and irq
	task automatic pulse(input int n, input int k, input logic [1:0] rr);
		@(posedge clk_sys);
		cmd[n][k] <= 1'b1;
		cmd[n][1:0] <= rr;
		@(posedge clk_sys);
		cmd[n][k] <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("Error at %0t: timeout", $time);
			stop_test();
		end
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hb66867a1));
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, (i < 6) ? 8'(4 * i) : 8'h3C, 8'h00);
			chk(q, 8'h00);
		end
		for (int n = 0; n < STAGES; n++) begin
			bus(1'b1, 8'(4 * n), 8'hFF);
			bus(1'b0, 8'(4 * n), 8'h00);
			chk(q, 8'h39);
			bus(1'b1, 8'(4 * n), 8'h00);
			pulse(n, 3, 2'($urandom % 4));
			r = 2'($urandom % 4);
			lr[n] = r;
			pulse(n, 2, r);
			pulse(n, 4, r);
			pulse(n, 6, r);
			pulse(n, 7, r);
			ex = exp_flags(r, 8'hD9);
			bus(1'b0, 8'(12 + 4 * n), 8'h00);
			chk(q, ex);
			chk({7'h00, stage_irq_req[n]}, 8'h00);
			bus(1'b1, 8'(12 + 4 * n), 8'h08);
			bus(1'b0, 8'(12 + 4 * n), 8'h00);
			chk(q, ex & 8'hF7);
			bus(1'b1, 8'(12 + 4 * n), 8'hFF);
			bus(1'b1, 8'h24, (n == 0) ? 8'h00 : 8'h07);
			for (int j = 0; j < 3; j++) begin
				bus(1'b1, 8'(4 * n), mk[j]);
				pulse(n, kk[j], r);
				chk({7'h00, stage_irq_req[n]}, 8'h01);
				chk({7'h00, irq}, {7'h00, n != 0});
				bus(1'b1, 8'(12 + 4 * n), 8'hFF);
				bus(1'b0, 8'h20, 8'h00);
				chk(q, 8'(1 << n));
				repeat (2) @(posedge clk_sys);
				chk({6'h00, irq, stage_irq_req[n]}, 8'h00);
			end
			bus(1'b1, 8'(4 * n), 8'h00);
		end
		// Stage 1 chained to stage 0, then stage 2 chained through both
		bus(1'b1, 8'h18, 8'h11);
		repeat (2) @(posedge clk_sys);
		chk({5'h00, stage_run}, 8'h03);
		bus(1'b1, 8'h18, 8'h31);
		repeat (2) @(posedge clk_sys);
		chk({5'h00, stage_run}, 8'h07);
		bus(1'b1, 8'h04, 8'h20);
		pulse(1, 5, lr[1]);
		chk({5'h00, stage_irq_req}, 8'h02);
		for (int m = 0; m < STAGES; m++) begin
			bus(1'b0, 8'(12 + 4 * m), 8'h00);
			chk(q, exp_flags(lr[m], (m > 0) ? 8'h20 : 8'h00));
		end
		// Ring wrap: stage 0 follows stage 2, end of cycle seen on stage 2 alone
		bus(1'b1, 8'h18, 8'h0C);
		repeat (2) @(posedge clk_sys);
		chk({5'h00, stage_run}, 8'h05);
		bus(1'b1, 8'h00, 8'h20);
		pulse(2, 4, lr[2]);
		chk({7'h00, stage_irq_req[0]}, 8'h01);
		bus(1'b0, 8'h0C, 8'h00);
		chk(q, exp_flags(lr[0], 8'h20));
		bus(1'b1, 8'h18, 8'h40);
		for (int v = 1; v < 3; v++) begin
			bus(1'b1, 8'h1C, 8'(v * 17));
			for (int m = 0; m < 2; m++) begin
				@(posedge clk_sys);
				cmd[2][1:0] <= 2'(m);
				repeat (4) @(posedge clk_sys);
				chk({4'h0, matrix_out.stage2_output_a0, matrix_out.stage2_output_a2,
					matrix_out.stage2_output_b1, matrix_out.stage2_output_b3},
					{4'h0, {4{v[m]}}});
			end
		end
		stop_test();
	end
endmodule
bind psef_top psef_monitor #(.STAGES(STAGES)) u_mon (.clk_sys(clk_sys), .rst_n(rst_n),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .stage_in(stage_in), .stage_run(stage_run),
	.stage_irq_req(stage_irq_req), .irq(irq));
